// ### include/hrw_pkg.sv
/*
  Shared constants for the hibernation controller with real-time clock:
  register offsets, field positions, reset values and timing counts.
  Assumes a 10 MHz system clock and a 32.768 kHz tick pin from the always-on domain.
*/
package hrw_pkg;
  // register byte offsets on the 32-bit bus
  localparam logic [7:0] HRW_OFS_CTRL    = 8'h00;
  localparam logic [7:0] HRW_OFS_SEC     = 8'h04;
  localparam logic [7:0] HRW_OFS_MATCH0  = 8'h08;
  localparam logic [7:0] HRW_OFS_SUBSEC  = 8'h0C;
  localparam logic [7:0] HRW_OFS_IEN     = 8'h10;
  localparam logic [7:0] HRW_OFS_RIS     = 8'h14;
  localparam logic [7:0] HRW_OFS_MIS     = 8'h18;
  localparam logic [7:0] HRW_OFS_ICLR    = 8'h1C;
  localparam logic [7:0] HRW_OFS_SAG     = 8'h20;
  localparam logic [7:0] HRW_OFS_WAKECFG = 8'h24;
  localparam logic [7:0] HRW_OFS_REQ     = 8'h28;
  localparam logic [7:0] HRW_OFS_MEM     = 8'h40;
  localparam logic [7:0] HRW_OFS_MEM_END = 8'h7C;

  // control register fields
  localparam int HRW_CTRL_ACTIVE  = 0;
  localparam int HRW_CTRL_RTC_EN  = 1;
  localparam int HRW_CTRL_HIB     = 2;
  localparam int HRW_CTRL_REG_ON  = 3;

  // interrupt bits, shared by enable, raw, masked and clear
  localparam int HRW_INT_WR_DONE  = 0;
  localparam int HRW_INT_PIN_WAKE = 1;
  localparam int HRW_INT_SAG      = 2;
  localparam int HRW_INT_MATCH0   = 3;
  localparam int HRW_INT_SUPPLY   = 4;
  localparam int HRW_INT_RST_WAKE = 5;
  localparam int HRW_INT_GPIO_WAKE = 6;
  localparam int HRW_INT_W        = 7;

  // battery sag register fields
  localparam int HRW_SAG_DETECT   = 0;
  localparam int HRW_SAG_ABORT    = 1;
  localparam int HRW_SAG_LVL_LO   = 4;
  localparam logic [1:0] sag_threshold_level0 = 2'h0; // 1.9 V
  localparam logic [1:0] sag_threshold_level1 = 2'h1; // 2.1 V
  localparam logic [1:0] sag_threshold_level2 = 2'h2; // 2.3 V
  localparam logic [1:0] sag_threshold_level3 = 2'h3; // 2.5 V

  // wake configuration fields
  localparam int HRW_WK_MATCH     = 0;
  localparam int HRW_WK_PIN       = 1;
  localparam int HRW_WK_RSTPIN    = 2;
  localparam int HRW_WK_GPIO      = 3;

  // request key written to the request register
  localparam logic [31:0] HRW_REQ_KEY  = 32'h0000_0001;

  // counters and storage
  localparam logic [14:0] HRW_SUBSEC_MAX = 15'h7FFF;
  localparam int HRW_MEM_WORDS    = 16;
  localparam logic [31:0] HRW_RST_WORD = 32'h0000_0000;
endpackage

// ### hdl/hrw_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes the first stage is read by the second stage only.
*/
module hrw_sync
  import hrw_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two stages, no reset needed on pure sampling flops
  always_ff @(posedge clk_sys_in) begin
    meta_r <= async_in;
    sync_r <= meta_r;
  end

  assign sync_out = sync_r;
endmodule

// ### hdl/hrw_rtc.sv
/*
  Seconds and sub-second counters with one match comparator.
  Assumes tick_in is a one-cycle pulse per 1/32768 s on the system clock.
*/
module hrw_rtc
  import hrw_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic        tick_in,
  input  wire logic        load_in,
  input  wire logic [31:0] load_val_in,
  input  wire logic [31:0] match_in,
  output logic      [31:0] sec_out,
  output logic      [14:0] subsec_out,
  output logic             match_out
);
  logic [31:0] sec_r;
  logic [14:0] sub_r;
  logic        match_r;
  logic        wrap;
  logic        hit;

  // sub-second wraps into a seconds step
  // wrap steps seconds
  assign wrap = run_in && tick_in && (sub_r == HRW_SUBSEC_MAX);
  assign hit  = run_in && (sec_r == match_in);

  // counters advance only while enabled; load restarts the second
  // loadable, steps per second
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sec_r   <= HRW_RST_WORD;
      sub_r   <= '0;
      match_r <= 1'b0;
    end else begin
      match_r <= hit && !match_r ? 1'b1 : hit;
      if (load_in) begin
        sec_r <= load_val_in;
        sub_r <= '0;
      end else if (run_in && tick_in) begin
        sub_r <= wrap ? '0 : sub_r + 15'h0001;
        if (wrap) sec_r <= sec_r + 32'h0000_0001;
      end
    end
  end

  assign sec_out    = sec_r;
  assign subsec_out = sub_r;
  // one pulse on the cycle the counter first equals the match
  assign match_out  = hit && !match_r;
endmodule

// ### hdl/hrw_top.sv
/*
  Hibernation controller: regulator enable, wake sources, battery sag,
  RTC with match, interrupt status and sixteen words of retained storage.
  Assumes an APB master on clk_sys_in, pins that are asynchronous, and
  rst_in driven only by the always-on supply, not by processor reset.
*/
// Our own choices: the APB interface to the registers and the address map.
module hrw_top
  import hrw_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tick_32k_in,
  input  wire logic        wake_pin_in,
  input  wire logic        reset_pin_in,
  input  wire logic        gpio_wake_in,
  input  wire logic        sag_lvl0_in,
  input  wire logic        sag_lvl1_in,
  input  wire logic        sag_lvl2_in,
  input  wire logic        sag_lvl3_in,
  input  wire logic        supply_fail_in,
  output logic             reg_enable_out,
  output logic             irq_out
);
  typedef enum logic [1:0] {HRW_RUN, HRW_HIB} hrw_state_t;

  // pin synchronisers
  logic [8:0] pins_sync;
  logic       tick_s, wake_s, rstp_s, gpio_s, fail_s;
  logic [3:0] lvl_s;

  hrw_sync #(.W(9)) u_sync (
    .clk_sys_in (clk_sys_in),
    .async_in   ({tick_32k_in, wake_pin_in, reset_pin_in, gpio_wake_in,
                  sag_lvl3_in, sag_lvl2_in, sag_lvl1_in, sag_lvl0_in, supply_fail_in}),
    .sync_out   (pins_sync)
  );

  assign {tick_s, wake_s, rstp_s, gpio_s} = pins_sync[8:5];
  assign lvl_s  = pins_sync[4:1];
  assign fail_s = pins_sync[0];

  // registers
  hrw_state_t           state_r, state_nxt;
  logic                 active_r;
  logic                 rtc_en_r;
  logic [31:0]          match0_r;
  logic [HRW_INT_W-1:0] ien_r;
  logic [HRW_INT_W-1:0] ris_r;
  logic [HRW_INT_W-1:0] ris_nxt;
  logic                 sag_det_r;
  logic                 sag_abort_r;
  logic [1:0]           sag_lvl_r;
  logic [3:0]           wake_cfg_r;
  logic                 tick_d_r;
  logic                 pin_d_r;
  logic                 rstp_d_r;
  logic                 gpio_d_r;
  logic                 fail_d_r;
  logic [31:0]          mem_r [HRW_MEM_WORDS];

  // bus decode
  logic        wr_acc, rd_acc, mem_hit, mapped;
  logic [3:0]  mem_idx;
  logic        wr_ctrl, wr_sec, wr_match, wr_ien, wr_iclr, wr_sag, wr_wake, wr_req;

  function automatic logic hit_at(input logic [7:0] a, input logic [7:0] ofs);
    hit_at = (a == ofs);
  endfunction

  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && !pwrite;
  assign mem_hit  = (paddr >= HRW_OFS_MEM) && (paddr <= HRW_OFS_MEM_END)
                    && (paddr[1:0] == 2'h0);
  assign mem_idx  = paddr[5:2];
  assign wr_ctrl  = wr_acc && hit_at(paddr, HRW_OFS_CTRL);
  assign wr_sec   = wr_acc && hit_at(paddr, HRW_OFS_SEC);
  assign wr_match = wr_acc && hit_at(paddr, HRW_OFS_MATCH0);
  assign wr_ien   = wr_acc && hit_at(paddr, HRW_OFS_IEN);
  assign wr_iclr  = wr_acc && hit_at(paddr, HRW_OFS_ICLR);
  assign wr_sag   = wr_acc && hit_at(paddr, HRW_OFS_SAG);
  assign wr_wake  = wr_acc && hit_at(paddr, HRW_OFS_WAKECFG);
  assign wr_req   = wr_acc && hit_at(paddr, HRW_OFS_REQ) && (pwdata == HRW_REQ_KEY);
  assign mapped   = mem_hit || hit_at(paddr, HRW_OFS_CTRL) || hit_at(paddr, HRW_OFS_SEC)
                    || hit_at(paddr, HRW_OFS_MATCH0) || hit_at(paddr, HRW_OFS_SUBSEC)
                    || hit_at(paddr, HRW_OFS_IEN) || hit_at(paddr, HRW_OFS_RIS)
                    || hit_at(paddr, HRW_OFS_MIS) || hit_at(paddr, HRW_OFS_ICLR)
                    || hit_at(paddr, HRW_OFS_SAG) || hit_at(paddr, HRW_OFS_WAKECFG)
                    || hit_at(paddr, HRW_OFS_REQ);

  // RTC core
  logic [31:0] sec;
  logic [14:0] subsec;
  logic        match_ev;

  hrw_rtc u_rtc (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .run_in      (rtc_en_r),
    .tick_in     (tick_s && !tick_d_r),
    .load_in     (wr_sec && rtc_en_r),
    .load_val_in (pwdata),
    .match_in    (match0_r),
    .sec_out     (sec),
    .subsec_out  (subsec),
    .match_out   (match_ev)
  );

  // event edges and sag comparison
  logic pin_ev, rstp_ev, gpio_ev, fail_ev, sag_low, sag_blk;

  assign pin_ev  = wake_s && !pin_d_r;
  assign rstp_ev = rstp_s && !rstp_d_r;
  assign gpio_ev = gpio_s && !gpio_d_r;
  assign fail_ev = fail_s && !fail_d_r;
  // level inputs high mean supply is below that threshold
  assign sag_low = lvl_s[sag_lvl_r];
  // abort blocks a request on sag
  assign sag_blk = sag_abort_r && sag_low;

  // wake decision from configured sources
  logic wake_any;

  assign wake_any = (wake_cfg_r[HRW_WK_MATCH] && match_ev)
                    || (wake_cfg_r[HRW_WK_PIN] && pin_ev)
                    || (wake_cfg_r[HRW_WK_RSTPIN] && rstp_ev)
                    || (wake_cfg_r[HRW_WK_GPIO] && gpio_ev);

  // hibernation state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HRW_RUN: begin
        if (wr_req && !sag_blk) state_nxt = HRW_HIB;
      end
      HRW_HIB: begin
        if (wake_any) state_nxt = HRW_RUN;
      end
      default: state_nxt = HRW_RUN;
    endcase
  end

  // raw status: set wins over clear
  always_comb begin
    ris_nxt = ris_r;
    if (wr_iclr) ris_nxt = ris_nxt & ~pwdata[HRW_INT_W-1:0];
    if (wr_acc) ris_nxt[HRW_INT_WR_DONE] = 1'b1;
    if (pin_ev) ris_nxt[HRW_INT_PIN_WAKE] = 1'b1;
    if (sag_det_r && sag_low) ris_nxt[HRW_INT_SAG] = 1'b1;
    if (match_ev) ris_nxt[HRW_INT_MATCH0] = 1'b1;
    if (fail_ev) ris_nxt[HRW_INT_SUPPLY] = 1'b1;
    if (rstp_ev) begin
      ris_nxt[HRW_INT_RST_WAKE]  = 1'b1;
      ris_nxt[HRW_INT_GPIO_WAKE] = 1'b1;
    end
    if (gpio_ev) ris_nxt[HRW_INT_GPIO_WAKE] = 1'b1;
  end

  // control and status flops
  // only the always-on reset clears these
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r     <= HRW_RUN;
      active_r    <= 1'b0;
      rtc_en_r    <= 1'b0;
      match0_r    <= HRW_RST_WORD;
      ien_r       <= '0;
      ris_r       <= '0;
      sag_det_r   <= 1'b0;
      sag_abort_r <= 1'b0;
      sag_lvl_r   <= sag_threshold_level0;
      wake_cfg_r  <= '0;
      tick_d_r    <= 1'b0;
      pin_d_r     <= 1'b0;
      rstp_d_r    <= 1'b0;
      gpio_d_r    <= 1'b0;
      fail_d_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      ris_r    <= ris_nxt;
      tick_d_r <= tick_s;
      pin_d_r  <= wake_s;
      rstp_d_r <= rstp_s;
      gpio_d_r <= gpio_s;
      fail_d_r <= fail_s;
      // active bit kept across processor reset
      if (wr_ctrl) begin
        active_r <= pwdata[HRW_CTRL_ACTIVE];
        rtc_en_r <= pwdata[HRW_CTRL_RTC_EN];
      end
      if (wr_match) match0_r <= pwdata;
      if (wr_ien) ien_r <= pwdata[HRW_INT_W-1:0];
      if (wr_sag) begin
        sag_det_r   <= pwdata[HRW_SAG_DETECT] || pwdata[HRW_SAG_ABORT];
        sag_abort_r <= pwdata[HRW_SAG_ABORT];
        sag_lvl_r   <= pwdata[HRW_SAG_LVL_LO +: 2];
      end
      if (wr_wake) wake_cfg_r <= pwdata[3:0];
    end
  end

  // retained storage, one flop row per word
  genvar gi;
  generate
    for (gi = 0; gi < HRW_MEM_WORDS; gi++) begin : g_mem
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          mem_r[gi] <= HRW_RST_WORD;
        end else if (wr_acc && mem_hit && (mem_idx == 4'(gi))) begin
          mem_r[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // read mux
  logic [HRW_INT_W-1:0] mis;
  logic [31:0]          ctrl_rd, sag_rd, rd_mux;

  assign mis     = ris_r & ien_r;
  assign ctrl_rd = {28'h0000000, (state_r == HRW_RUN), (state_r == HRW_HIB),
                    rtc_en_r, active_r};
  assign sag_rd  = {26'h0000000, sag_lvl_r, 2'h0, sag_abort_r, sag_det_r};

  assign rd_mux = mem_hit ? mem_r[mem_idx] :
                  hit_at(paddr, HRW_OFS_CTRL)    ? ctrl_rd :
                  hit_at(paddr, HRW_OFS_SEC)     ? sec :
                  hit_at(paddr, HRW_OFS_MATCH0)  ? match0_r :
                  hit_at(paddr, HRW_OFS_SUBSEC)  ? {17'h00000, subsec} :
                  hit_at(paddr, HRW_OFS_IEN)     ? {25'h0000000, ien_r} :
                  hit_at(paddr, HRW_OFS_RIS)     ? {25'h0000000, ris_r} :
                  hit_at(paddr, HRW_OFS_MIS)     ? {25'h0000000, mis} :
                  hit_at(paddr, HRW_OFS_SAG)     ? sag_rd :
                  hit_at(paddr, HRW_OFS_WAKECFG) ? {28'h0000000, wake_cfg_r} :
                  32'h0000_0000;

  // read data registered in the setup cycle
  logic [31:0] prdata_r;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_acc && !penable) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1; // zero wait states
  assign pslverr = psel && penable && !mapped;

  assign reg_enable_out = (state_r != HRW_HIB);
  assign irq_out = |mis;
endmodule

// ### tb/hrw_checker.sv
/*
  Checker for hrw_top: bus errors, regulator enable and interrupts.
  Assumes pin levels stay steady for several cycles around each event.
*/
module hrw_checker
  import hrw_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wake_pin_in,
  input wire logic        reset_pin_in,
  input wire logic        sag_lvl0_in,
  input wire logic        sag_lvl1_in,
  input wire logic        sag_lvl2_in,
  input wire logic        sag_lvl3_in,
  input wire logic        reg_enable_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] sag_r;
  logic [3:0] wk_r;
  logic [6:0] ien_r;
  // bus decode and selected sag level
  wire       wr     = psel && penable && pwrite && pready;
  wire       mapped = (paddr[1:0] == 2'h0) && ((paddr <= HRW_OFS_REQ) ||
                      ((paddr >= HRW_OFS_MEM) && (paddr <= HRW_OFS_MEM_END)));
  wire [3:0] lvl    = {sag_lvl3_in, sag_lvl2_in, sag_lvl1_in, sag_lvl0_in};
  wire       req    = wr && (paddr == HRW_OFS_REQ) && (pwdata == HRW_REQ_KEY);
  wire       held   = sag_r[HRW_SAG_ABORT] && lvl[sag_r[5:4]];
  // shadow copies of the host configuration
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sag_r <= 6'h00;
      wk_r  <= 4'h0;
      ien_r <= 7'h00;
    end else if (wr) begin
      if (paddr == HRW_OFS_SAG) sag_r <= pwdata[5:0];
      if (paddr == HRW_OFS_WAKECFG) wk_r <= pwdata[3:0];
      if (paddr == HRW_OFS_IEN) ien_r <= pwdata[6:0];
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_reset_state: assert property (disable iff (1'b0) rst_in |=> reg_enable_out && !irq_out)
    else $error("outputs wrong after reset");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("bus error flag wrong");
  a_request_drops: assert property (req && !held && reg_enable_out |=> !reg_enable_out)
    else $error("regulator not dropped");
  a_abort_holds: assert property (req && held && reg_enable_out |=> reg_enable_out[*4])
    else $error("regulator dropped despite abort");
  a_pin_wakes: assert property (!reg_enable_out && wk_r[HRW_WK_PIN] && $rose(wake_pin_in)
    |-> ##[1:6] reg_enable_out)
    else $error("no wake from pin");
  a_rstpin_wakes: assert property (!reg_enable_out && wk_r[HRW_WK_RSTPIN] && $rose(reset_pin_in)
    |-> ##[1:6] reg_enable_out)
    else $error("no wake from reset pin");
  a_irq_masked: assert property (ien_r == 7'h00 |-> !irq_out)
    else $error("interrupt with all enables off");
  a_sag_irq: assert property (sag_r[HRW_SAG_DETECT] && lvl[sag_r[5:4]] && ien_r[HRW_INT_SAG]
    |-> ##[0:6] irq_out)
    else $error("sag interrupt missing");
  a_read_stands: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed");
endmodule

bind hrw_top hrw_checker u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wake_pin_in(wake_pin_in), .reset_pin_in(reset_pin_in), .sag_lvl0_in(sag_lvl0_in),
  .sag_lvl1_in(sag_lvl1_in), .sag_lvl2_in(sag_lvl2_in), .sag_lvl3_in(sag_lvl3_in),
  .reg_enable_out(reg_enable_out), .irq_out(irq_out)
);

// ### tb/hrw_partner.sv
/*
  Far side model: external regulator and the 32 kHz source.
  Assumes one tick edge per two system cycles while a burst runs.
*/
module hrw_partner (
  input  wire logic        clk_sys_in,
  input  wire logic        tick_en_in,
  input  wire logic        reg_enable_in,
  output logic             tick_out = 1'b0,
  output logic [15:0]      tick_cnt_out = 16'h0000,
  output logic             powered_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lag_r = 2'h3;
  // supply follows the enable with a short lag
  assign powered_out = lag_r[1];
  // source stands low outside bursts; rising edges are counted
  always @(posedge clk_sys_in) begin
    lag_r <= {lag_r[0], reg_enable_in};
    tick_out <= tick_en_in && !tick_out;
    if (tick_en_in && !tick_out) tick_cnt_out <= tick_cnt_out + 16'h0001;
  end
endmodule

// ### tb/hrw_top_tb.sv
/*
  Testbench for hrw_top: registers over APB, RTC, interrupts, sag, hibernation.
  Assumes hrw_partner drives the 32 kHz source and models the regulator.
*/
module hrw_top_tb
  import hrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  pins       = 4'h0; // supply, gpio, reset pin, wake pin
  logic [3:0]  sag_lvl    = 4'h0;
  logic        tick_en    = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, tick, reg_enable_out, irq_out, powered, err;
  logic [15:0] tick_cnt;
  int          fails       = 0;
  int          check_count = 0;
  // 10 MHz clock
  always #50 clk_sys_in = ~clk_sys_in;
  hrw_top uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick_32k_in(tick), .wake_pin_in(pins[0]), .reset_pin_in(pins[1]),
    .gpio_wake_in(pins[2]), .sag_lvl0_in(sag_lvl[0]), .sag_lvl1_in(sag_lvl[1]),
    .sag_lvl2_in(sag_lvl[2]), .sag_lvl3_in(sag_lvl[3]), .supply_fail_in(pins[3]),
    .reg_enable_out(reg_enable_out), .irq_out(irq_out)
  );
  hrw_partner far (
    .clk_sys_in(clk_sys_in), .tick_en_in(tick_en), .reg_enable_in(reg_enable_out),
    .tick_out(tick), .tick_cnt_out(tick_cnt), .powered_out(powered)
  );
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  // one APB transfer; read data and error taken at the completing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      conclude();
    end
  endtask
  task automatic wait_en(input logic v);
    int n;
    for (n = 0; n < 20 && reg_enable_out !== v; n++) @(posedge clk_sys_in);
    chk("reg_enable", 32'(v), 32'(reg_enable_out));
    if (n >= 20) conclude();
  endtask
  task automatic pulse(input logic [3:0] m);
    pins <= m;
    repeat (4) @(posedge clk_sys_in);
    pins <= 4'h0;
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic tickn(input int n);
    logic [15:0] t;
    int k;
    t = tick_cnt + n[15:0];
    tick_en <= 1'b1;
    for (k = 0; k < 3 * n + 9 && tick_cnt !== t; k++) @(posedge clk_sys_in);
    tick_en <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    if (tick_cnt !== t) begin
      fails++;
      conclude();
    end
  endtask
  task automatic t_regs();
    xfer(0, HRW_OFS_CTRL, 0);
    chk("ctrl reset", 32'h0000_0008, rd);
    xfer(1, HRW_OFS_MATCH0, 32'h0000_0006);
    xfer(0, HRW_OFS_MATCH0, 0);
    chk("match0", 32'h0000_0006, rd);
    for (int l = 0; l < 4; l++) begin
      xfer(1, HRW_OFS_SAG, {26'h0, l[1:0], 4'h3});
      xfer(0, HRW_OFS_SAG, 0);
      chk("sag cfg", {26'h0, l[1:0], 4'h3}, rd);
    end
    xfer(1, HRW_OFS_MEM_END, 32'h5A5A_A5A5);
    xfer(0, HRW_OFS_MEM_END, 0);
    chk("mem last", 32'h5A5A_A5A5, rd);
    xfer(0, 8'h30, 0);
    chk("unmapped err", 32'h1, 32'(err));
  endtask
  task automatic t_rtc();
    xfer(1, HRW_OFS_SEC, 32'h0000_0005);
    xfer(0, HRW_OFS_SEC, 0);
    chk("sec rtc off", 32'h0, rd);
    xfer(1, HRW_OFS_CTRL, 32'h0000_0003);
    xfer(1, HRW_OFS_SEC, 32'h0000_0005);
    tickn(32767);
    xfer(0, HRW_OFS_SUBSEC, 0);
    chk("subsec top", 32'h0000_7FFF, rd);
    xfer(0, HRW_OFS_SEC, 0);
    chk("sec held", 32'h0000_0005, rd);
    tickn(1);
    xfer(0, HRW_OFS_SEC, 0);
    chk("sec step", 32'h0000_0006, rd);
    xfer(0, HRW_OFS_SUBSEC, 0);
    chk("subsec wrap", 32'h0, rd);
    xfer(0, HRW_OFS_RIS, 0);
    chk("match flag", 32'h8, rd & 32'h8);
  endtask
  task automatic t_irq();
    xfer(1, HRW_OFS_ICLR, 32'h0000_007F);
    xfer(0, HRW_OFS_RIS, 0);
    chk("cleared", 32'h0, rd & 32'h7E);
    pulse(4'h8);
    xfer(0, HRW_OFS_RIS, 0);
    chk("supply raw", 32'h10, rd & 32'h7E);
    pulse(4'h4);
    xfer(0, HRW_OFS_RIS, 0);
    chk("gpio raw", 32'h40, rd & 32'h60);
    xfer(1, HRW_OFS_IEN, 32'h0000_0010);
    xfer(0, HRW_OFS_MIS, 0);
    chk("supply masked", 32'h10, rd);
    chk("irq on", 32'h1, 32'(irq_out));
    xfer(1, HRW_OFS_IEN, 32'h0);
    xfer(0, HRW_OFS_MIS, 0);
    chk("masked off", 32'h0, rd);
    chk("irq off", 32'h0, 32'(irq_out));
  endtask
  task automatic t_sag();
    xfer(1, HRW_OFS_SAG, {26'h0, sag_threshold_level1, 4'h3});
    sag_lvl <= 4'h2;
    xfer(1, HRW_OFS_IEN, 32'h0000_0004);
    repeat (4) @(posedge clk_sys_in);
    xfer(0, HRW_OFS_MIS, 0);
    chk("sag masked", 32'h4, rd);
    xfer(1, HRW_OFS_REQ, HRW_REQ_KEY);
    // host keeps running after the request
    repeat (6) @(posedge clk_sys_in);
    chk("aborted", 32'h1, 32'(reg_enable_out));
    sag_lvl <= 4'h0;
    xfer(1, HRW_OFS_SAG, 32'h0);
    xfer(1, HRW_OFS_IEN, 32'h0);
  endtask
  task automatic t_hib();
    xfer(1, HRW_OFS_MEM, 32'hA5A5_5A5A);
    xfer(1, HRW_OFS_WAKECFG, 32'h0000_0006);
    for (int k = 0; k < 2; k++) begin
      xfer(1, HRW_OFS_ICLR, 32'h0000_007F);
      xfer(1, HRW_OFS_REQ, HRW_REQ_KEY);
      wait_en(1'b0);
      repeat (3) @(posedge clk_sys_in);
      chk("power off", 32'h0, 32'(powered));
      pulse(k ? 4'h2 : 4'h1);
      wait_en(1'b1);
      xfer(0, HRW_OFS_RIS, 0);
      chk("wake cause", k ? 32'h60 : 32'h02, rd & 32'h62);
    end
    xfer(1, HRW_OFS_MATCH0, 32'h0000_0009);
    xfer(1, HRW_OFS_WAKECFG, 32'h0000_0001);
    xfer(1, HRW_OFS_REQ, HRW_REQ_KEY);
    wait_en(1'b0);
    xfer(1, HRW_OFS_SEC, 32'h0000_0009);
    wait_en(1'b1);
    xfer(0, HRW_OFS_RIS, 0);
    chk("match wake", 32'h8, rd & 32'h8);
    xfer(0, HRW_OFS_CTRL, 0);
    chk("active kept", 32'h1, rd & 32'h1);
    xfer(0, HRW_OFS_MEM, 0);
    chk("mem kept", 32'hA5A5_5A5A, rd);
  endtask
  // reset for 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_regs();
    t_rtc();
    t_irq();
    t_sag();
    t_hib();
    conclude();
  end
endmodule
